// [design/cond_eval.sv]
// Condition test for conditional call and return.
// Assumes flags come from logic on the same clock, parity flag high = even.
`timescale 1ns/100ps
module cond_eval (
	input  wire logic [2:0] cond_i,
	input  wire logic       flag_zero_i,
	input  wire logic       flag_carry_i,
	input  wire logic       flag_parity_i,
	input  wire logic       flag_sign_i,
	output logic            met_o
);
	logic flag_sel;

	// Pick the flag by the upper bits, low bit says true or false sense
	always_comb begin
		case (cond_i[2:1])
			2'h0:    flag_sel = flag_zero_i;
			2'h1:    flag_sel = flag_carry_i;
			2'h2:    flag_sel = flag_parity_i;
			default: flag_sel = flag_sign_i;
		endcase
		met_o = cond_i[0] ? flag_sel : ~flag_sel;
	end
endmodule

// [design/cpu8_dec_pkg.sv]
// Shared constants for the 8-bit opcode decoder: opcode patterns,
// operand field codes, cycle counts, instruction classes and states.
// Assumes every user refers to items as cpu8_dec_pkg::name.
package cpu8_dec_pkg;

	// Opcode patterns, wildcards mark operand fields
	localparam logic [7:0] OP_CALL       = 8'hcd;
	localparam logic [7:0] OP_CALL_COND  = 8'b11???100;
	localparam logic [7:0] OP_RET        = 8'hc9;
	localparam logic [7:0] OP_RET_COND   = 8'b11???000;
	localparam logic [7:0] OP_RESTART    = 8'b11???111;
	localparam logic [7:0] OP_PORT_IN    = 8'hdb;
	localparam logic [7:0] OP_PORT_OUT   = 8'hd3;
	localparam logic [7:0] OP_INC_REG    = 8'b00???100;
	localparam logic [7:0] OP_DEC_REG    = 8'b00???101;
	localparam logic [7:0] OP_INC_PAIR   = 8'b00??0011;
	localparam logic [7:0] OP_DEC_PAIR   = 8'b00??1011;
	localparam logic [7:0] OP_DOUBLE_ADD = 8'b00??1001;
	localparam logic [7:0] OP_ALU_REG    = 8'b10??????;
	localparam logic [7:0] OP_ALU_IMM    = 8'b11???110;
	localparam logic [7:0] OP_ROTATE     = 8'b000??111;
	localparam logic [7:0] OP_SPECIAL    = 8'b001??111;
	localparam logic [7:0] OP_IRQ_EN     = 8'hfb;
	localparam logic [7:0] OP_IRQ_DIS    = 8'hf3;
	localparam logic [7:0] OP_NO_OP      = 8'h00;
	localparam logic [7:0] OP_HALT       = 8'h76;
	localparam logic [7:0] OP_READ_MASK  = 8'h20;
	localparam logic [7:0] OP_SET_MASK   = 8'h30;

	// Register field codes
	localparam logic [2:0] REG_B   = 3'h0;
	localparam logic [2:0] REG_C   = 3'h1;
	localparam logic [2:0] REG_D   = 3'h2;
	localparam logic [2:0] REG_E   = 3'h3;
	localparam logic [2:0] REG_H   = 3'h4;
	localparam logic [2:0] REG_L   = 3'h5;
	localparam logic [2:0] REG_MEM = 3'h6;
	localparam logic [2:0] REG_ACC = 3'h7;

	// Condition field codes
	localparam logic [2:0] COND_NOT_ZERO  = 3'h0;
	localparam logic [2:0] COND_ZERO      = 3'h1;
	localparam logic [2:0] COND_NO_CARRY  = 3'h2;
	localparam logic [2:0] COND_CARRY     = 3'h3;
	localparam logic [2:0] COND_PAR_ODD   = 3'h4;
	localparam logic [2:0] COND_PAR_EVEN  = 3'h5;
	localparam logic [2:0] COND_POSITIVE  = 3'h6;
	localparam logic [2:0] COND_MINUS     = 3'h7;

	// Clock-cycle counts per instruction form
	localparam int          CYC_W          = 5;
	localparam logic [4:0] CYC_CALL       = 5'h12; // 18
	localparam logic [4:0] CYC_CALL_SKIP  = 5'h09;
	localparam logic [4:0] CYC_RET        = 5'h0a; // 10
	localparam logic [4:0] CYC_RET_SKIP   = 5'h06;
	localparam logic [4:0] CYC_RET_TAKEN  = 5'h0c; // 12
	localparam logic [4:0] CYC_RESTART    = 5'h0c;
	localparam logic [4:0] CYC_PORT       = 5'h0a;
	localparam logic [4:0] CYC_INCDEC_REG = 5'h04;
	localparam logic [4:0] CYC_INCDEC_MEM = 5'h0a;
	localparam logic [4:0] CYC_PAIR       = 5'h06;
	localparam logic [4:0] CYC_ALU_REG    = 5'h04;
	localparam logic [4:0] CYC_ALU_MEM    = 5'h07;
	localparam logic [4:0] CYC_DOUBLE_ADD = 5'h0a;
	localparam logic [4:0] CYC_SHORT      = 5'h04;
	localparam logic [4:0] CYC_HALT       = 5'h05;
	localparam logic [4:0] CYC_NONE       = 5'h00;

	// Operand byte counts after the opcode
	localparam logic [1:0] BYTES_NONE = 2'h0;
	localparam logic [1:0] BYTES_ONE  = 2'h1;
	localparam logic [1:0] BYTES_TWO  = 2'h2;

	// Instruction classes reported to the sequencer
	typedef enum logic [4:0] {
		CLS_UNSUPPORTED = 5'h00,
		CLS_CALL        = 5'h01,
		CLS_CALL_COND   = 5'h02,
		CLS_RET         = 5'h03,
		CLS_RET_COND    = 5'h04,
		CLS_RESTART     = 5'h05,
		CLS_PORT_IN     = 5'h06,
		CLS_PORT_OUT    = 5'h07,
		CLS_INC_REG     = 5'h08,
		CLS_DEC_REG     = 5'h09,
		CLS_INC_PAIR    = 5'h0a,
		CLS_DEC_PAIR    = 5'h0b,
		CLS_ALU         = 5'h0c,
		CLS_DOUBLE_ADD  = 5'h0d,
		CLS_ROTATE      = 5'h0e,
		CLS_SPECIAL     = 5'h0f,
		CLS_IRQ_EN      = 5'h10,
		CLS_IRQ_DIS     = 5'h11,
		CLS_NO_OP       = 5'h12,
		CLS_HALT        = 5'h13,
		CLS_READ_MASK   = 5'h14,
		CLS_SET_MASK    = 5'h15
	} class_t;

	// Decoder sequencing states, one-hot
	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_EXEC = 3'b010,
		ST_HALT = 3'b100
	} state_t;

	// Flag state after reset
	localparam logic IRQ_EN_RESET = 1'b0;

endpackage

// [design/cpu8_opcode_decoder.sv]
// Opcode decoder for the call, return, restart, port, increment/decrement,
// arithmetic, logical, rotate, special and control groups of an 8-bit CPU.
// Assumes opcode, strobe and flags come from fetch logic on clk_i.
`timescale 1ns/100ps
module cpu8_opcode_decoder (
	input  wire logic                 clk_i,
	input  wire logic                 rstn_i,
	input  wire logic [7:0]           opcode_i,
	input  wire logic                 opcode_valid_i,
	input  wire logic                 flag_zero_i,
	input  wire logic                 flag_carry_i,
	input  wire logic                 flag_parity_i,
	input  wire logic                 flag_sign_i,
	input  wire logic                 wake_i,
	output logic                      ready_o,
	output logic                      decode_valid_o,
	output cpu8_dec_pkg::class_t      class_o,
	output logic      [2:0]           alu_op_o,
	output logic      [7:0]           dest_sel_o,
	output logic      [7:0]           src_sel_o,
	output logic      [1:0]           pair_o,
	output logic      [2:0]           cond_o,
	output logic                      cond_met_o,
	output logic      [2:0]           vector_o,
	output logic      [1:0]           operand_bytes_o,
	output logic                      mem_access_o,
	output logic      [4:0]           cycles_o,
	output logic                      irq_enable_o,
	output logic                      halted_o
);
	// All state of the decoder
	typedef struct packed {
		cpu8_dec_pkg::state_t state;
		logic [4:0]           cnt;
		cpu8_dec_pkg::class_t cls;
		logic [2:0]           alu_op;
		logic [7:0]           dest_sel;
		logic [7:0]           src_sel;
		logic [1:0]           pair;
		logic [2:0]           cond;
		logic                 met;
		logic [2:0]           vector;
		logic [1:0]           bytes;
		logic                 mem;
		logic [4:0]           cycles;
		logic                 valid;
		logic                 irq_en;
	} dec_state_t;

	localparam dec_state_t RESET_STATE = '{
		state:    cpu8_dec_pkg::ST_IDLE,
		cnt:      cpu8_dec_pkg::CYC_NONE,
		cls:      cpu8_dec_pkg::CLS_UNSUPPORTED,
		alu_op:   3'h0,
		dest_sel: 8'h00,
		src_sel:  8'h00,
		pair:     2'h0,
		cond:     3'h0,
		met:      1'b0,
		vector:   3'h0,
		bytes:    cpu8_dec_pkg::BYTES_NONE,
		mem:      1'b0,
		cycles:   cpu8_dec_pkg::CYC_NONE,
		valid:    1'b0,
		irq_en:   cpu8_dec_pkg::IRQ_EN_RESET
	};

	dec_state_t cur_ff;
	dec_state_t nxt_cur;

	logic       take;
	logic       cond_met;
	logic [7:0] dest_onehot;
	logic [7:0] src_onehot;
	logic       dest_is_mem;
	logic       src_is_mem;

	// flag check
	// Condition sits in bits 5..3 for both call and return
	cond_eval u_cond (
		.cond_i        (opcode_i[5:3]),
		.flag_zero_i   (flag_zero_i),
		.flag_carry_i  (flag_carry_i),
		.flag_parity_i (flag_parity_i),
		.flag_sign_i   (flag_sign_i),
		.met_o         (cond_met)
	);

	// field encoding
	// Destination field in bits 5..3, source field in bits 2..0
	reg_field_decode #(
		.NUM_REGS (8)
	) u_dest (
		.field_i  (opcode_i[5:3]),
		.sel_o    (dest_onehot),
		.is_mem_o (dest_is_mem)
	);

	reg_field_decode #(
		.NUM_REGS (8)
	) u_src (
		.field_i  (opcode_i[2:0]),
		.sel_o    (src_onehot),
		.is_mem_o (src_is_mem)
	);

	// A new opcode is accepted only while idle
	assign take = opcode_valid_i && (cur_ff.state == cpu8_dec_pkg::ST_IDLE);

	// Next-state logic: decode on take, then hold busy for the cycle count
	always_comb begin
		nxt_cur       = cur_ff;
		nxt_cur.valid = 1'b0;
		case (cur_ff.state)
			cpu8_dec_pkg::ST_IDLE: begin
				if (take) begin
					nxt_cur.valid    = 1'b1;
					nxt_cur.cls      = cpu8_dec_pkg::CLS_UNSUPPORTED;
					nxt_cur.alu_op   = opcode_i[5:3];
					nxt_cur.dest_sel = 8'h00;
					nxt_cur.src_sel  = 8'h00;
					nxt_cur.pair     = opcode_i[5:4];
					nxt_cur.cond     = opcode_i[5:3];
					nxt_cur.met      = 1'b1;
					nxt_cur.vector   = opcode_i[5:3];
					nxt_cur.bytes    = cpu8_dec_pkg::BYTES_NONE;
					nxt_cur.mem      = 1'b0;
					nxt_cur.cycles   = cpu8_dec_pkg::CYC_NONE;
					// Exact opcodes first, field patterns after
					casez (opcode_i)
						cpu8_dec_pkg::OP_CALL: begin
							nxt_cur.cls    = cpu8_dec_pkg::CLS_CALL;
							nxt_cur.bytes  = cpu8_dec_pkg::BYTES_TWO;
							nxt_cur.mem    = 1'b1;
							nxt_cur.cycles = cpu8_dec_pkg::CYC_CALL;
						end
						cpu8_dec_pkg::OP_RET: begin
							nxt_cur.cls    = cpu8_dec_pkg::CLS_RET;
							nxt_cur.mem    = 1'b1;
							nxt_cur.cycles = cpu8_dec_pkg::CYC_RET;
						end
						cpu8_dec_pkg::OP_PORT_IN: begin
							nxt_cur.cls    = cpu8_dec_pkg::CLS_PORT_IN;
							nxt_cur.bytes  = cpu8_dec_pkg::BYTES_ONE;
							nxt_cur.cycles = cpu8_dec_pkg::CYC_PORT;
						end
						cpu8_dec_pkg::OP_PORT_OUT: begin
							nxt_cur.cls    = cpu8_dec_pkg::CLS_PORT_OUT;
							nxt_cur.bytes  = cpu8_dec_pkg::BYTES_ONE;
							nxt_cur.cycles = cpu8_dec_pkg::CYC_PORT;
						end
						cpu8_dec_pkg::OP_IRQ_EN: begin
							nxt_cur.cls    = cpu8_dec_pkg::CLS_IRQ_EN;
							nxt_cur.irq_en = 1'b1;
							nxt_cur.cycles = cpu8_dec_pkg::CYC_SHORT;
						end
						cpu8_dec_pkg::OP_IRQ_DIS: begin
							nxt_cur.cls    = cpu8_dec_pkg::CLS_IRQ_DIS;
							nxt_cur.irq_en = 1'b0;
							nxt_cur.cycles = cpu8_dec_pkg::CYC_SHORT;
						end
						cpu8_dec_pkg::OP_NO_OP: begin
							nxt_cur.cls    = cpu8_dec_pkg::CLS_NO_OP;
							nxt_cur.cycles = cpu8_dec_pkg::CYC_SHORT;
						end
						cpu8_dec_pkg::OP_HALT: begin
							nxt_cur.cls    = cpu8_dec_pkg::CLS_HALT;
							nxt_cur.cycles = cpu8_dec_pkg::CYC_HALT;
						end
						cpu8_dec_pkg::OP_READ_MASK: begin
							nxt_cur.cls    = cpu8_dec_pkg::CLS_READ_MASK;
							nxt_cur.cycles = cpu8_dec_pkg::CYC_SHORT;
						end
						cpu8_dec_pkg::OP_SET_MASK: begin
							nxt_cur.cls    = cpu8_dec_pkg::CLS_SET_MASK;
							nxt_cur.cycles = cpu8_dec_pkg::CYC_SHORT;
						end
						cpu8_dec_pkg::OP_CALL_COND: begin
							nxt_cur.cls    = cpu8_dec_pkg::CLS_CALL_COND;
							nxt_cur.bytes  = cpu8_dec_pkg::BYTES_TWO;
							nxt_cur.met    = cond_met;
							nxt_cur.mem    = cond_met;
							nxt_cur.cycles = cond_met ? cpu8_dec_pkg::CYC_CALL
								: cpu8_dec_pkg::CYC_CALL_SKIP;
						end
						cpu8_dec_pkg::OP_RET_COND: begin
							nxt_cur.cls    = cpu8_dec_pkg::CLS_RET_COND;
							nxt_cur.met    = cond_met;
							nxt_cur.mem    = cond_met;
							nxt_cur.cycles = cond_met ? cpu8_dec_pkg::CYC_RET_TAKEN
								: cpu8_dec_pkg::CYC_RET_SKIP;
						end
						// restart to vector in bits 5..3
						cpu8_dec_pkg::OP_RESTART: begin
							nxt_cur.cls    = cpu8_dec_pkg::CLS_RESTART;
							nxt_cur.mem    = 1'b1;
							nxt_cur.cycles = cpu8_dec_pkg::CYC_RESTART;
						end
						cpu8_dec_pkg::OP_ALU_IMM: begin
							nxt_cur.cls     = cpu8_dec_pkg::CLS_ALU;
							nxt_cur.bytes   = cpu8_dec_pkg::BYTES_ONE;
							nxt_cur.dest_sel = 8'h80;
							nxt_cur.cycles  = cpu8_dec_pkg::CYC_ALU_MEM;
						end
						cpu8_dec_pkg::OP_INC_REG: begin
							nxt_cur.cls      = cpu8_dec_pkg::CLS_INC_REG;
							nxt_cur.dest_sel = dest_onehot;
							nxt_cur.mem      = dest_is_mem;
							nxt_cur.cycles   = dest_is_mem ? cpu8_dec_pkg::CYC_INCDEC_MEM
								: cpu8_dec_pkg::CYC_INCDEC_REG;
						end
						cpu8_dec_pkg::OP_DEC_REG: begin
							nxt_cur.cls      = cpu8_dec_pkg::CLS_DEC_REG;
							nxt_cur.dest_sel = dest_onehot;
							nxt_cur.mem      = dest_is_mem;
							nxt_cur.cycles   = dest_is_mem ? cpu8_dec_pkg::CYC_INCDEC_MEM
								: cpu8_dec_pkg::CYC_INCDEC_REG;
						end
						cpu8_dec_pkg::OP_INC_PAIR: begin
							nxt_cur.cls    = cpu8_dec_pkg::CLS_INC_PAIR;
							nxt_cur.cycles = cpu8_dec_pkg::CYC_PAIR;
						end
						cpu8_dec_pkg::OP_DEC_PAIR: begin
							nxt_cur.cls    = cpu8_dec_pkg::CLS_DEC_PAIR;
							nxt_cur.cycles = cpu8_dec_pkg::CYC_PAIR;
						end
						// pair added into the address pair
						cpu8_dec_pkg::OP_DOUBLE_ADD: begin
							nxt_cur.cls    = cpu8_dec_pkg::CLS_DOUBLE_ADD;
							nxt_cur.cycles = cpu8_dec_pkg::CYC_DOUBLE_ADD;
						end
						cpu8_dec_pkg::OP_ROTATE: begin
							nxt_cur.cls      = cpu8_dec_pkg::CLS_ROTATE;
							nxt_cur.dest_sel = 8'h80;
							nxt_cur.cycles   = cpu8_dec_pkg::CYC_SHORT;
						end
						cpu8_dec_pkg::OP_SPECIAL: begin
							nxt_cur.cls    = cpu8_dec_pkg::CLS_SPECIAL;
							nxt_cur.cycles = cpu8_dec_pkg::CYC_SHORT;
						end
						// arithmetic and logical forms from register or memory
						cpu8_dec_pkg::OP_ALU_REG: begin
							nxt_cur.cls      = cpu8_dec_pkg::CLS_ALU;
							nxt_cur.dest_sel = 8'h80;
							nxt_cur.src_sel  = src_onehot;
							nxt_cur.mem      = src_is_mem;
							nxt_cur.cycles   = src_is_mem ? cpu8_dec_pkg::CYC_ALU_MEM
								: cpu8_dec_pkg::CYC_ALU_REG;
						end
						default: begin
							nxt_cur.cls = cpu8_dec_pkg::CLS_UNSUPPORTED;
						end
					endcase
					// Halt parks the decoder; other counts above one hold it busy
					if (opcode_i == cpu8_dec_pkg::OP_HALT) begin
						nxt_cur.state = cpu8_dec_pkg::ST_HALT;
					end else if (nxt_cur.cycles > 5'h01) begin
						nxt_cur.state = cpu8_dec_pkg::ST_EXEC;
						nxt_cur.cnt   = nxt_cur.cycles - 5'h01;
					end
				end
			end
			cpu8_dec_pkg::ST_EXEC: begin
				nxt_cur.cnt = cur_ff.cnt - 5'h01;
				if (cur_ff.cnt == 5'h01)
					nxt_cur.state = cpu8_dec_pkg::ST_IDLE;
			end
			cpu8_dec_pkg::ST_HALT: begin
				if (wake_i)
					nxt_cur.state = cpu8_dec_pkg::ST_IDLE;
			end
			default: begin
				nxt_cur.state = cpu8_dec_pkg::ST_IDLE;
			end
		endcase
	end

	// State register
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i)
			cur_ff <= RESET_STATE;
		else
			cur_ff <= nxt_cur;
	end

	// Outputs straight from the state register
	assign ready_o         = (cur_ff.state == cpu8_dec_pkg::ST_IDLE);
	assign decode_valid_o  = cur_ff.valid;
	assign class_o         = cur_ff.cls;
	assign alu_op_o        = cur_ff.alu_op;
	assign dest_sel_o      = cur_ff.dest_sel;
	assign src_sel_o       = cur_ff.src_sel;
	assign pair_o          = cur_ff.pair;
	assign cond_o          = cur_ff.cond;
	assign cond_met_o      = cur_ff.met;
	assign vector_o        = cur_ff.vector;
	assign operand_bytes_o = cur_ff.bytes;
	assign mem_access_o    = cur_ff.mem;
	assign cycles_o        = cur_ff.cycles;
	assign irq_enable_o    = cur_ff.irq_en;
	assign halted_o        = (cur_ff.state == cpu8_dec_pkg::ST_HALT);
endmodule

// [design/reg_field_decode.sv]
// Turns a three-bit register operand field into a one-hot register select.
// Assumes the field is taken straight from the opcode byte.
`timescale 1ns/100ps
module reg_field_decode #(
	parameter int NUM_REGS = 8
) (
	input  wire logic [2:0]          field_i,
	output logic      [NUM_REGS-1:0] sel_o,
	output logic                     is_mem_o
);
	// Elaboration check: the field is three bits wide, so eight codes exactly
	if (NUM_REGS != 8) begin : g_bad_count
		$error("reg_field_decode needs exactly eight register codes");
	end

	// One select line per register code
	for (genvar i = 0; i < NUM_REGS; i++) begin : g_sel
		assign sel_o[i] = (field_i == 3'(i));
	end

	// Memory through the address pair
	assign is_mem_o = (field_i == cpu8_dec_pkg::REG_MEM);
endmodule

// [sim/cpu8_opcode_decoder_props.sv]
// Concurrent checks on the ports of the opcode decoder.
// Assumes it is bound onto cpu8_opcode_decoder, one clock domain.
`timescale 1ns/100ps
module cpu8_opcode_decoder_props (
	input  wire logic                 clk_i,
	input  wire logic                 rstn_i,
	input  wire logic [7:0]           opcode_i,
	input  wire logic                 opcode_valid_i,
	input  wire logic                 wake_i,
	input  wire logic                 ready_o,
	input  wire logic                 decode_valid_o,
	input  wire cpu8_dec_pkg::class_t class_o,
	input  wire logic [2:0]           alu_op_o,
	input  wire logic [1:0]           pair_o,
	input  wire logic [2:0]           cond_o,
	input  wire logic                 cond_met_o,
	input  wire logic [2:0]           vector_o,
	input  wire logic                 mem_access_o,
	input  wire logic [4:0]           cycles_o,
	input  wire logic                 irq_enable_o,
	input  wire logic                 halted_o
);
	// Opcode accepted at this edge
	logic take;
	assign take = opcode_valid_i && ready_o;

	default clocking @(posedge clk_i); endclocking
	default disable iff (!rstn_i);

	chk_call_count: assert property (
		take && opcode_i == 8'hcd |=> decode_valid_o && cycles_o == 5'h12
			&& class_o == cpu8_dec_pkg::CLS_CALL) else $error("call decode wrong");
	chk_cond_call: assert property (
		take && opcode_i ==? 8'b11???100 |=> cond_o == $past(opcode_i[5:3])
			&& cycles_o == (cond_met_o ? 5'h12 : 5'h09)) else $error("cond call wrong");
	chk_cond_ret: assert property (
		take && opcode_i ==? 8'b11???000 |=> decode_valid_o
			&& cycles_o == (cond_met_o ? 5'h0c : 5'h06)) else $error("cond return wrong");
	chk_restart_vector: assert property (
		take && opcode_i ==? 8'b11???111 |=> vector_o == $past(opcode_i[5:3])
			&& cycles_o == 5'h0c && mem_access_o) else $error("restart decode wrong");
	chk_pair_no_mem: assert property (
		decode_valid_o && (class_o == cpu8_dec_pkg::CLS_INC_PAIR
			|| class_o == cpu8_dec_pkg::CLS_DEC_PAIR) |-> cycles_o == 5'h06
			&& !mem_access_o) else $error("pair step wrong");
	chk_alu_busy_span: assert property (
		take && opcode_i ==? 8'b10?????? && opcode_i[2:0] != 3'h6
			|=> !ready_o [*3] ##1 ready_o) else $error("register alu span wrong");
	chk_alu_mem_form: assert property (
		take && opcode_i ==? 8'b10???110 |=> cycles_o == 5'h07 && mem_access_o)
		else $error("memory alu form wrong");
	chk_special_four: assert property (
		take && opcode_i ==? 8'b00???111 |=> cycles_o == 5'h04 && !mem_access_o)
		else $error("rotate or special count wrong");
	chk_irq_follow: assert property (
		take && (opcode_i == 8'hfb || opcode_i == 8'hf3)
			|=> irq_enable_o == $past(opcode_i[3])) else $error("irq enable wrong");
	chk_halt_enter: assert property (
		take && opcode_i == 8'h76 |=> halted_o && !ready_o && cycles_o == 5'h05)
		else $error("halt entry wrong");
	chk_wake_release: assert property (
		halted_o && wake_i |=> !halted_o && ready_o) else $error("wake release wrong");
	chk_field_copy: assert property (
		take |=> pair_o == $past(opcode_i[5:4]) && alu_op_o == $past(opcode_i[5:3]))
		else $error("operand field copy wrong");
endmodule

bind cpu8_opcode_decoder cpu8_opcode_decoder_props u_props (
	.clk_i(clk_i), .rstn_i(rstn_i), .opcode_i(opcode_i), .opcode_valid_i(opcode_valid_i),
	.wake_i(wake_i), .ready_o(ready_o), .decode_valid_o(decode_valid_o), .class_o(class_o),
	.alu_op_o(alu_op_o), .pair_o(pair_o),
	.cond_o(cond_o), .cond_met_o(cond_met_o), .vector_o(vector_o),
	.mem_access_o(mem_access_o), .cycles_o(cycles_o), .irq_enable_o(irq_enable_o),
	.halted_o(halted_o)
);

// [sim/cpu8_opcode_decoder_test.sv]
// Self-checking bench: every opcode, then random ones, with random flags.
// Assumes the decoder, its package, the checker and the fetch model.
`timescale 1ns/100ps
module cpu8_opcode_decoder_test;
	typedef struct packed {
		logic [4:0]           cls;
		logic [4:0]           cyc;
		logic                 met;
		logic [1:0]           nb;
		logic                 mem;
		logic [7:0]           dst;
		logic [7:0]           src;
	} note_t;

	logic                 clk_i;
	logic                 rstn_i;
	logic [7:0]           opcode_i;
	logic                 opcode_valid_i;
	logic [3:0]           flags;
	logic                 wake_i;
	logic                 ready_o;
	logic                 decode_valid_o;
	cpu8_dec_pkg::class_t class_o;
	logic [7:0]           dest_sel_o;
	logic [7:0]           src_sel_o;
	logic                 cond_met_o;
	logic [1:0]           operand_bytes_o;
	logic                 mem_access_o;
	logic [4:0]           cycles_o;
	logic                 irq_enable_o;
	logic                 halted_o;
	note_t                notes[$];
	note_t                got;
	int                   miscompares;
	int                   checks_done;
	logic [31:0]          lfsr;

	cpu8_opcode_decoder DUT (
		.clk_i(clk_i), .rstn_i(rstn_i), .opcode_i(opcode_i), .opcode_valid_i(opcode_valid_i),
		.flag_zero_i(flags[0]), .flag_carry_i(flags[1]), .flag_parity_i(flags[2]),
		.flag_sign_i(flags[3]), .wake_i(wake_i), .ready_o(ready_o),
		.decode_valid_o(decode_valid_o), .class_o(class_o), .alu_op_o(), .dest_sel_o(dest_sel_o),
		.src_sel_o(src_sel_o), .pair_o(), .cond_o(), .cond_met_o(cond_met_o), .vector_o(),
		.operand_bytes_o(operand_bytes_o), .mem_access_o(mem_access_o), .cycles_o(cycles_o),
		.irq_enable_o(irq_enable_o), .halted_o(halted_o)
	);

	fetch_model u_fetch (
		.clk_i(clk_i), .rstn_i(rstn_i), .ready_i(ready_o),
		.opcode_valid_o(opcode_valid_i), .opcode_o(opcode_i)
	);

	// Compare one value and count it
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			miscompares++;
			$display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
		end
	endtask

	task automatic print_verdict;
		$display("checks %0d, miscompares %0d", checks_done, miscompares);
		if (miscompares == 0 && checks_done > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	function automatic logic [31:0] lfsr_next(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction

	// Expected decode; f holds sign, parity, carry, zero from bit 3 down
	function automatic note_t expect_of(input logic [7:0] op, input logic [3:0] f);
		note_t n;
		logic  met;
		n = '0;
		met = (f[op[5:4]] == op[3]);
		casez (op)
			8'hcd: {n.cls, n.cyc} = {cpu8_dec_pkg::CLS_CALL, 5'h12};
			8'hc9: {n.cls, n.cyc} = {cpu8_dec_pkg::CLS_RET, 5'h0a};
			8'hdb: {n.cls, n.cyc} = {cpu8_dec_pkg::CLS_PORT_IN, 5'h0a};
			8'hd3: {n.cls, n.cyc} = {cpu8_dec_pkg::CLS_PORT_OUT, 5'h0a};
			8'hfb: {n.cls, n.cyc} = {cpu8_dec_pkg::CLS_IRQ_EN, 5'h04};
			8'hf3: {n.cls, n.cyc} = {cpu8_dec_pkg::CLS_IRQ_DIS, 5'h04};
			8'h00: {n.cls, n.cyc} = {cpu8_dec_pkg::CLS_NO_OP, 5'h04};
			8'h76: {n.cls, n.cyc} = {cpu8_dec_pkg::CLS_HALT, 5'h05};
			8'h20: {n.cls, n.cyc} = {cpu8_dec_pkg::CLS_READ_MASK, 5'h04};
			8'h30: {n.cls, n.cyc} = {cpu8_dec_pkg::CLS_SET_MASK, 5'h04};
			8'b11???100: {n.cls, n.cyc} = {cpu8_dec_pkg::CLS_CALL_COND, met ? 5'h12 : 5'h09};
			8'b11???000: {n.cls, n.cyc} = {cpu8_dec_pkg::CLS_RET_COND, met ? 5'h0c : 5'h06};
			8'b11???111: {n.cls, n.cyc} = {cpu8_dec_pkg::CLS_RESTART, 5'h0c};
			8'b11???110: {n.cls, n.cyc} = {cpu8_dec_pkg::CLS_ALU, 5'h07};
			8'b00???100: {n.cls, n.cyc} = {cpu8_dec_pkg::CLS_INC_REG, op[5:3] == 3'h6 ? 5'h0a : 5'h04};
			8'b00???101: {n.cls, n.cyc} = {cpu8_dec_pkg::CLS_DEC_REG, op[5:3] == 3'h6 ? 5'h0a : 5'h04};
			8'b00??0011: {n.cls, n.cyc} = {cpu8_dec_pkg::CLS_INC_PAIR, 5'h06};
			8'b00??1011: {n.cls, n.cyc} = {cpu8_dec_pkg::CLS_DEC_PAIR, 5'h06};
			8'b00??1001: {n.cls, n.cyc} = {cpu8_dec_pkg::CLS_DOUBLE_ADD, 5'h0a};
			8'b10??????: {n.cls, n.cyc} = {cpu8_dec_pkg::CLS_ALU, op[2:0] == 3'h6 ? 5'h07 : 5'h04};
			8'b000??111: {n.cls, n.cyc} = {cpu8_dec_pkg::CLS_ROTATE, 5'h04};
			8'b001??111: {n.cls, n.cyc} = {cpu8_dec_pkg::CLS_SPECIAL, 5'h04};
			default: n.cls = cpu8_dec_pkg::CLS_UNSUPPORTED;
		endcase
		n.met = (op ==? 8'b11???100 || op ==? 8'b11???000) && op != 8'hcd ? met : 1'b1;
		n.nb = (op ==? 8'b11???100 || op == 8'hcd) ? 2'h2
			: (op == 8'hdb || op == 8'hd3 || op ==? 8'b11???110) ? 2'h1 : 2'h0;
		n.mem = op == 8'hcd || op == 8'hc9 || op ==? 8'b11???111 || op == 8'h34 || op == 8'h35
			|| op ==? 8'b10???110 || ((op ==? 8'b11???100 || op ==? 8'b11???000) && met);
		n.dst = (op ==? 8'b00???10?) ? 8'h01 << op[5:3]
			: (op ==? 8'b10?????? || op ==? 8'b11???110 || op ==? 8'b000??111) ? 8'h80 : 8'h00;
		n.src = (op ==? 8'b10??????) ? 8'h01 << op[2:0] : 8'h00;
		return n;
	endfunction

	// Issue one opcode with fresh flags and wait for its decode
	task automatic run_op(input logic [7:0] op);
		int n;
		n = 0;
		while (!(ready_o === 1'b1 && opcode_valid_i === 1'b0) && n < 60) begin
			@(negedge clk_i);
			n++;
		end
		@(posedge clk_i);
		lfsr = lfsr_next(lfsr);
		flags <= lfsr[3:0];
		@(negedge clk_i);
		notes.push_back(expect_of(op, flags));
		u_fetch.push(op);
		n = 0;
		while (decode_valid_o !== 1'b1 && n < 60) begin
			@(negedge clk_i);
			n++;
		end
		check(32'(n < 60), 32'h1);
		if (op == 8'hfb || op == 8'hf3) check(32'(irq_enable_o), 32'(op[3]));
		if (op == 8'h76) begin
			repeat (4) @(negedge clk_i);
			check(32'({halted_o, ready_o}), 32'h2);
			@(posedge clk_i);
			wake_i <= 1'b1;
			@(posedge clk_i);
			wake_i <= 1'b0;
		end
	endtask

	initial begin
		clk_i = 1'b0;
		forever #2 clk_i = ~clk_i;
	end

	// Watchdog against a hang
	initial begin
		repeat (20000) @(posedge clk_i);
		miscompares++;
		print_verdict;
	end

	// Compare each decode with the oldest note
	always @(posedge clk_i) begin
		if (decode_valid_o === 1'b1) begin
			if (notes.size() == 0) begin
				miscompares++;
				$display("unexpected at %0t: decode with no request", $time);
			end else begin
				got = notes.pop_front();
				check(32'({class_o, cycles_o}), 32'({got.cls, got.cyc}));
				check(32'({cond_met_o, operand_bytes_o}), 32'({got.met, got.nb}));
				check(32'({mem_access_o, dest_sel_o, src_sel_o}), 32'({got.mem, got.dst, got.src}));
			end
		end
	end

	// Reset, then all opcodes in order, then random ones
	initial begin
		rstn_i = 1'b0;
		flags = 4'h0;
		wake_i = 1'b0;
		lfsr = 32'h6c90;
		miscompares = 0;
		checks_done = 0;
		repeat (12) @(posedge clk_i);
		rstn_i <= 1'b1;
		@(negedge clk_i);
		check(32'({ready_o, decode_valid_o, class_o, irq_enable_o, halted_o}), 32'h100);
		for (int i = 0; i < 320; i++) begin
			run_op(i < 256 ? 8'(i) : lfsr[15:8]);
		end
		run_op(8'hf3);
		repeat (8) @(posedge clk_i);
		print_verdict;
	end
endmodule

// [sim/fetch_model.sv]
// Fetch path model: presents queued opcodes and holds each until taken.
// Assumes the decoder takes an opcode on an edge where ready is high.
`timescale 1ns/100ps
module fetch_model (
	input  wire logic       clk_i,
	input  wire logic       rstn_i,
	input  wire logic       ready_i,
	output logic            opcode_valid_o,
	output logic [7:0]      opcode_o
);
	logic [7:0] pending[$];

	// Queue one opcode for presentation
	task automatic push(input logic [7:0] op);
		pending.push_back(op);
	endtask

	// Hold the request until taken; idle bus shows a changing pattern
	always @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			opcode_valid_o <= 1'b0;
			opcode_o       <= 8'h00;
		end else if (!opcode_valid_o || ready_i) begin
			if (pending.size() > 0) begin
				opcode_valid_o <= 1'b1;
				opcode_o       <= pending.pop_front();
			end else begin
				opcode_valid_o <= 1'b0;
				opcode_o       <= ~opcode_o;
			end
		end
	end
endmodule
